// ---- rtl/circ_top.sv ----
// contact input run control with its register slave
`timescale 1ns/1ps
`default_nettype none

// Function
// - three contacts, one and two fully configurable
// - polarity normally-open or normally-closed, default open
// - form latched or pulsed, default latched
// - per-input function choice with listed defaults
// - input one run makes input two stop
// - input three pulsed, only polarity configurable
// - latched run/stop runs while input active
// - pulsed run/stop toggles on each activation
// - stop wins when start and stop active
// - start on input one, stop on two
// - monitor samples only after start delay
// - switch off only after persistence time
// - detection raises per-input alarm
// - stop by run/stop suppresses later alarm
// - zero delay monitors always, else running only
// - delay 0 to 300 s, persistence 0 to 10 s
// - alarm action off, continue or stop
// - monitoring only for external switch inputs
// - input three is fixed mode request
module circ_top
  import circ_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = circ_pkg::TICK_CYCLES
)
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // ahb-lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  // contact inputs, raw
  input  wire logic [circ_pkg::N_IN-1:0] contact_in,
  // results
  output logic                           run,
  output logic                           input_one_detection_alarm,
  output logic                           input_two_detection_alarm,
  output logic                           continue_on_alarm,
  output logic                           stop_on_alarm,
  output logic                           mode_request
);
  import circ_pkg::*;

  logic [N_IN-1:0]  sync1_q;
  logic [N_IN-1:0]  sync2_q;
  logic [N_IN-1:0]  act_prev_q;
  logic [N_IN-1:0]  act;
  logic [N_IN-1:0]  rise;
  logic [N_IN-1:0]  pol_q;
  logic [N_CFG-1:0] form_q;
  logic [1:0]       func_q   [N_CFG];
  logic [1:0]       act_q    [N_CFG];
  logic [DLY_W-1:0] delay_q  [N_CFG];
  logic [OFF_W-1:0] offdet_q [N_CFG];
  logic [N_CFG-1:0] alarm_q;
  logic [N_CFG-1:0] armed;
  logic [N_CFG-1:0] detect;
  logic [N_CFG-1:0] clr_req;
  logic [TICK_W-1:0] tick_cnt_q;
  logic             tick_q;
  logic             run_q;
  logic             run_d;
  logic             mode_req_q;
  logic             fault_hold;
  logic             pair_mode;
  logic             wr_pend_q;
  logic             rd_pend_q;
  logic [7:0]       addr_q;
  logic             map_q;
  logic [31:0]      hrdata_q;
  logic             hreadyout_q;
  logic             hresp_q;
  logic             accept;

  // input one set to run pairs it with input two as stop
  function automatic logic is_pair(input logic [1:0] f1);
    return f1 == FUNC_PAIR;
  endfunction

  function automatic logic is_ext(input logic [1:0] f);
    return f == FUNC_EXT;
  endfunction

  function automatic logic [DLY_W-1:0] clip_delay(input logic [DLY_W-1:0] v);
    return (v > DELAY_MAX_S) ? DELAY_MAX_S : v;
  endfunction

  function automatic logic [OFF_W-1:0] clip_off(input logic [OFF_W-1:0] v);
    return (v > OFFDET_MAX_S) ? OFFDET_MAX_S : v;
  endfunction

  // contacts are asynchronous to clk; second stage feeds all logic
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_sync
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= contact_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
      assign act[gi]  = sync2_q[gi] ^ pol_q[gi];
      assign rise[gi] = act[gi] & ~act_prev_q[gi];
    end
  endgenerate

  // previous active level starts high, but the synchroniser starts low, so a held contact still gives an edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      act_prev_q <= '1;
    end else begin
      act_prev_q <= act;
    end
  end

  // one-second tick for delay and persistence timers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(TICK_CYCLES_P - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  // input three: pulsed form, fixed mode request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_req_q <= 1'b0;
    end else begin
      mode_req_q <= rise[N_IN-1];
    end
  end

  // monitors for the two configurable inputs
  generate
    for (gi = 0; gi < N_CFG; gi++) begin : g_mon
      circ_swmon u_mon (
        .clk      (clk),
        .reset    (reset),
        .tick     (tick_q),
        .run      (run_q),
        .enable   (is_ext(func_q[gi])),
        .delay    (delay_q[gi]),
        .offdet   (offdet_q[gi]),
        .sw_on    (act[gi]),
        .armed_q  (armed[gi]),
        .detect_q (detect[gi])
      );
      // set wins over a software clear in the same cycle
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          alarm_q[gi] <= 1'b0;
        end else if (detect[gi] && act_q[gi] != ACT_OFF) begin
          alarm_q[gi] <= 1'b1;
        end else if (clr_req[gi] || act_q[gi] == ACT_OFF) begin
          alarm_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign pair_mode  = is_pair(func_q[0]);
  assign fault_hold = (alarm_q[0] && act_q[0] == ACT_FLT) ||
                      (alarm_q[1] && act_q[1] == ACT_FLT);

  // run command decode; input one wins if both are set to run/stop
  always_comb begin
    run_d = run_q;
    if (pair_mode) begin
      if (rise[0] && !act[1]) begin
        run_d = 1'b1;
      end
      if (act[1]) begin
        run_d = 1'b0;
      end
    end else if (func_q[0] == FUNC_RS) begin
      if (form_q[0] == LATCHED_LEVEL_FORM) begin
        run_d = act[0];
      end else if (rise[0]) begin
        run_d = ~run_q;
      end
    end else if (func_q[1] == FUNC_RS) begin
      if (form_q[1] == LATCHED_LEVEL_FORM) begin
        run_d = act[1];
      end else if (rise[1]) begin
        run_d = ~run_q;
      end
    end
    if (fault_hold) begin
      run_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  // ahb-lite: writes take no wait, reads one wait state
  assign accept = hsel && hready && htrans[HTRANS_ACT];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      addr_q      <= '0;
      map_q       <= 1'b0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      wr_pend_q   <= accept && hwrite;
      rd_pend_q   <= accept && !hwrite;
      if (accept) begin
        addr_q <= haddr[7:0];
        map_q  <= haddr[31:8] == '0;
      end
      hreadyout_q <= !(accept && !hwrite);
    end
  end

  // read mux sampled one cycle after the address so earlier writes show
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata_q <= '0;
    end else if (rd_pend_q) begin
      hrdata_q <= '0;
      if (map_q) begin
        for (int i = 0; i < N_CFG; i++) begin
          if (addr_q == ADDR_DELAY0 + ADDR_STRIDE * 8'(i)) begin
            hrdata_q[DLY_W-1:0] <= delay_q[i];
          end
          if (addr_q == ADDR_OFF0 + ADDR_STRIDE * 8'(i)) begin
            hrdata_q[OFF_W-1:0] <= offdet_q[i];
          end
        end
        case (addr_q)
          ADDR_CFG: begin
            for (int i = 0; i < N_IN; i++) begin
              hrdata_q[i*CFG_STRIDE+POL_OFS] <= pol_q[i];
            end
            for (int i = 0; i < N_CFG; i++) begin
              hrdata_q[i*CFG_STRIDE+FORM_OFS] <= form_q[i];
              hrdata_q[i*CFG_STRIDE+FUNC_OFS +: 2] <= func_q[i];
            end
          end
          ADDR_ACT: begin
            for (int i = 0; i < N_CFG; i++) begin
              hrdata_q[i*ACT_STRIDE +: 2] <= act_q[i];
            end
          end
          ADDR_STATUS: begin
            hrdata_q[ST_RUN]           <= run_q;
            hrdata_q[ST_ALM +: N_CFG]  <= alarm_q;
            hrdata_q[ST_ARM +: N_CFG]  <= armed;
            hrdata_q[ST_IN +: N_IN]    <= act;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // configuration writes; input three polarity is its only setting
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pol_q       <= {N_IN{POL_NO}};
      form_q      <= {N_CFG{LATCHED_LEVEL_FORM}};
      func_q[0]   <= FUNC_RS;
      func_q[1]   <= FUNC_EXT;
      act_q[0]    <= ACT_FLT;
      act_q[1]    <= ACT_FLT;
      delay_q[0]  <= DELAY_RST;
      delay_q[1]  <= DELAY_RST;
      offdet_q[0] <= OFFDET_RST;
      offdet_q[1] <= OFFDET_RST;
    end else if (wr_pend_q && map_q) begin
      if (addr_q == ADDR_CFG) begin
        for (int i = 0; i < N_IN; i++) begin
          pol_q[i] <= hwdata[i*CFG_STRIDE+POL_OFS];
        end
        for (int i = 0; i < N_CFG; i++) begin
          form_q[i] <= hwdata[i*CFG_STRIDE+FORM_OFS];
          func_q[i] <= hwdata[i*CFG_STRIDE+FUNC_OFS +: 2];
        end
      end
      if (addr_q == ADDR_ACT) begin
        for (int i = 0; i < N_CFG; i++) begin
          act_q[i] <= (hwdata[i*ACT_STRIDE +: 2] > ACT_FLT) ?
                      ACT_FLT : hwdata[i*ACT_STRIDE +: 2];
        end
      end
      for (int i = 0; i < N_CFG; i++) begin
        if (addr_q == ADDR_DELAY0 + ADDR_STRIDE * 8'(i)) begin
          delay_q[i] <= clip_delay(hwdata[DLY_W-1:0]);
        end
        if (addr_q == ADDR_OFF0 + ADDR_STRIDE * 8'(i)) begin
          offdet_q[i] <= clip_off(hwdata[OFF_W-1:0]);
        end
      end
    end
  end

  assign clr_req = (wr_pend_q && map_q && addr_q == ADDR_CLEAR) ?
                   hwdata[N_CFG-1:0] : '0;

  // ports straight from flops
  assign hrdata                    = hrdata_q;
  assign hreadyout                 = hreadyout_q;
  assign hresp                     = hresp_q;
  assign run                       = run_q;
  assign input_one_detection_alarm = alarm_q[0];
  assign input_two_detection_alarm = alarm_q[1];
  assign mode_request              = mode_req_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      continue_on_alarm <= 1'b0;
      stop_on_alarm     <= 1'b0;
    end else begin
      continue_on_alarm <= (alarm_q[0] && act_q[0] == ACT_WRN) ||
                           (alarm_q[1] && act_q[1] == ACT_WRN);
      stop_on_alarm     <= fault_hold;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence fault_rise_s;
    $rose(alarm_q[0]) && act_q[0] == ACT_FLT;
  endsequence

  fault_stops_a: assert property (fault_rise_s |=> !run_q)
    else $error("fault alarm did not stop operation");
  stop_priority_a: assert property (pair_mode && act[1] |=> !run_q)
    else $error("stop input did not win");
  pair_start_a: assert property (
    pair_mode && rise[0] && !act[1] && !fault_hold |=> run_q)
    else $error("start input did not start");
  latch_follow_a: assert property (
    func_q[0] == FUNC_RS && form_q[0] == LATCHED_LEVEL_FORM && !fault_hold
    |=> run_q == $past(act[0]))
    else $error("latched run does not follow input");
  pulse_toggle_a: assert property (
    func_q[0] == FUNC_RS && form_q[0] == PULSED_EDGE_FORM && rise[0]
    && !fault_hold |=> run_q != $past(run_q))
    else $error("pulsed input did not toggle");
  mode_pulse_a: assert property (rise[2] |=> mode_req_q ##1 !mode_req_q)
    else $error("mode request not a single pulse");
  tick_gap_a: assert property (tick_q |=> !tick_q [*8])
    else $error("tick too frequent");
  alarm_cause_a: assert property ($rose(alarm_q[1]) |-> $past(detect[1]))
    else $error("alarm raised without detection");
  clear_alarm_a: assert property (
    clr_req[0] && !detect[0] |=> !alarm_q[0])
    else $error("alarm clear ignored");
  read_wait_a: assert property (accept && !hwrite |=> !hreadyout_q ##1 hreadyout_q)
    else $error("read wait state wrong");

endmodule : circ_top

`default_nettype wire

// ---- rtl/circ_pkg.sv ----
// constants for the contact input run control block
package circ_pkg;

  // clock and timer scaling
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TICK_S      = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int unsigned TICK_W      = 26;

  // setting ranges in seconds
  localparam int unsigned DLY_W        = 9;
  localparam int unsigned OFF_W        = 4;
  localparam logic [8:0]  DELAY_MAX_S  = 9'h12C;
  localparam logic [3:0]  OFFDET_MAX_S = 4'hA;
  localparam logic [8:0]  DELAY_RST    = 9'h000;
  localparam logic [3:0]  OFFDET_RST   = 4'h0;

  // contact counts
  localparam int unsigned N_IN  = 3;
  localparam int unsigned N_CFG = 2;

  // input function encodings
  localparam logic [1:0] FUNC_OFF = 2'h0;
  localparam logic [1:0] FUNC_EXT = 2'h1;
  localparam logic [1:0] FUNC_RS  = 2'h2;
  localparam logic [1:0] FUNC_PAIR = 2'h3;

  // alarm action encodings
  localparam logic [1:0] ACT_OFF  = 2'h0;
  localparam logic [1:0] ACT_WRN  = 2'h1;
  localparam logic [1:0] ACT_FLT  = 2'h2;

  // polarity and form encodings
  localparam logic POL_NO            = 1'b0;
  localparam logic LATCHED_LEVEL_FORM = 1'b0;
  localparam logic PULSED_EDGE_FORM   = 1'b1;

  // register byte offsets
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_ACT    = 8'h04;
  localparam logic [7:0] ADDR_DELAY0 = 8'h08;
  localparam logic [7:0] ADDR_OFF0   = 8'h0C;
  localparam logic [7:0] ADDR_STRIDE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_CLEAR  = 8'h1C;

  // configuration field layout, one group of four bits per input
  localparam int unsigned CFG_STRIDE = 4;
  localparam int unsigned POL_OFS    = 0;
  localparam int unsigned FORM_OFS   = 1;
  localparam int unsigned FUNC_OFS   = 2;
  localparam int unsigned ACT_STRIDE = 2;

  // status layout
  localparam int unsigned ST_RUN   = 0;
  localparam int unsigned ST_ALM   = 1;
  localparam int unsigned ST_ARM   = 3;
  localparam int unsigned ST_IN    = 8;

  // htrans bit that marks an active transfer
  localparam int unsigned HTRANS_ACT = 1;

endpackage : circ_pkg

// ---- rtl/circ_swmon.sv ----
// external switch monitor: start delay and off persistence
`timescale 1ns/1ps
`default_nettype none

module circ_swmon
  import circ_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // timing and state
  input  wire logic                        tick,
  input  wire logic                        run,
  // setting
  input  wire logic                        enable,
  input  wire logic [circ_pkg::DLY_W-1:0]  delay,
  input  wire logic [circ_pkg::OFF_W-1:0]  offdet,
  // switch level after polarity
  input  wire logic                        sw_on,
  // result
  output logic                             armed_q,
  output logic                             detect_q
);
  import circ_pkg::*;

  logic [DLY_W-1:0] dly_cnt_q;
  logic [OFF_W-1:0] off_cnt_q;
  logic             armed_d;

  // seconds of operation since start; reset on stop so each run restarts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dly_cnt_q <= '0;
    end else if (!run) begin
      dly_cnt_q <= '0;
    end else if (tick && dly_cnt_q < delay) begin
      dly_cnt_q <= dly_cnt_q + 1'b1;
    end
  end

  // zero delay monitors always; otherwise only while running
  always_comb begin
    armed_d = enable && (delay == '0 || (run && dly_cnt_q >= delay));
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
    end
  end

  // off time counted in whole seconds; any on level restarts it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      off_cnt_q <= '0;
    end else if (!armed_q || sw_on) begin
      off_cnt_q <= '0;
    end else if (tick && off_cnt_q < offdet) begin
      off_cnt_q <= off_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      detect_q <= 1'b0;
    end else begin
      detect_q <= armed_q && armed_d && !sw_on && off_cnt_q >= offdet;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence switch_off_s;
    !sw_on;
  endsequence

  arm_needs_run_a: assert property (armed_q && delay != '0 |-> $past(run))
    else $error("monitor armed while stopped");
  detect_after_off_a: assert property ($rose(detect_q) |-> $past(!sw_on))
    else $error("detect without switch off");
  detect_disabled_a: assert property (!enable |=> ##1 !detect_q)
    else $error("detect on input not set to monitor");
  stop_disarms_a: assert property ((!run && delay != '0) |=> !armed_q)
    else $error("monitor still armed after stop");
  zero_delay_arm_a: assert property (enable && delay == '0 |=> armed_q)
    else $error("zero delay did not arm");
  off_immediate_a: assert property (
    (armed_q && armed_d && offdet == '0) and switch_off_s |=> detect_q)
    else $error("zero persistence did not detect");

endmodule : circ_swmon

`default_nettype wire

// ---- verification/circ_contact_model.sv ----
// model of the customer equipment that closes the dry contacts
`timescale 1ns/1ps
`default_nettype none

module circ_contact_model
(
  // clock
  input  wire logic       clk,
  // wanted active state, contact type, answer speed
  input  wire logic [2:0] want,
  input  wire logic [2:0] nc,
  input  wire logic       slow,
  // contact pins
  output logic      [2:0] pins
);
  logic [2:0] lag1_q;
  logic [2:0] lag2_q;
  logic [2:0] lag3_q;

  // a slow relay closes three cycles late, like real contactor hardware
  always @(posedge clk) begin
    lag1_q <= want;
    lag2_q <= lag1_q;
    lag3_q <= lag2_q;
  end

  // a normally-closed contact opens when its signal is active
  always @(posedge clk) begin
    pins <= (slow ? lag3_q : want) ^ nc;
  end
endmodule : circ_contact_model

`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the contact input run control block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import circ_pkg::*;
  localparam int unsigned TK = 20;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        run;
  logic        alm1;
  logic        alm2;
  logic        cont;
  logic        stp;
  logic        mreq;
  logic [2:0]  want = 3'h0;
  logic [2:0]  nc = 3'h0;
  logic        slow = 1'b0;
  logic [2:0]  pins;
  logic [31:0] rd;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #12.5 clk = ~clk;

  circ_top #(.TICK_CYCLES_P(TK)) u_dut (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .contact_in(pins), .run(run),
    .input_one_detection_alarm(alm1), .input_two_detection_alarm(alm2),
    .continue_on_alarm(cont), .stop_on_alarm(stp), .mode_request(mreq)
  );

  circ_contact_model u_contacts (
    .clk(clk), .want(want), .nc(nc), .slow(slow), .pins(pins)
  );

  task automatic finish_test();
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp($sformatf("reg %h", a), exp, rd);
  endtask : chk_reg

  // writing the configuration also clears both alarms
  task automatic cfg(input logic [31:0] c);
    bus(1'b1, ADDR_CFG, c);
    bus(1'b1, ADDR_CLEAR, 32'h3);
  endtask : cfg

  // pins reach run four edges later; nine covers a slow relay too
  task automatic set_in(input logic [2:0] w);
    want <= w;
    repeat (9) @(posedge clk);
  endtask : set_in

  task automatic t_defaults();
    chk_reg(ADDR_CFG, 32'h48);
    chk_reg(ADDR_ACT, 32'hA);
    chk_reg(ADDR_DELAY0, 32'h0);
    chk_reg(ADDR_OFF0, 32'h0);
    chk_reg(8'h20, 32'h0);
    bus(1'b1, ADDR_DELAY0, 32'h1FF);
    chk_reg(ADDR_DELAY0, 32'h12C);
    bus(1'b1, ADDR_OFF0, 32'hF);
    chk_reg(ADDR_OFF0, 32'hA);
    bus(1'b1, ADDR_DELAY0, 32'h0);
    bus(1'b1, ADDR_OFF0, 32'h0);
  endtask : t_defaults

  task automatic t_runstop();
    cfg(32'h08);
    set_in(3'h1);
    cmp("run latched on", 32'h1, {31'h0, run});
    chk_reg(ADDR_STATUS, 32'h101);
    set_in(3'h0);
    cmp("run latched off", 32'h0, {31'h0, run});
    cfg(32'h0A);
    slow <= 1'b1;
    set_in(3'h1);
    cmp("run pulse start", 32'h1, {31'h0, run});
    set_in(3'h0);
    cmp("run pulse hold", 32'h1, {31'h0, run});
    set_in(3'h1);
    cmp("run pulse stop", 32'h0, {31'h0, run});
    set_in(3'h0);
    slow <= 1'b0;
    cfg(32'h09);
    nc <= 3'h1;
    set_in(3'h0);
    cmp("run nc open", 32'h0, {31'h0, run});
    set_in(3'h1);
    cmp("run nc closed", 32'h1, {31'h0, run});
    set_in(3'h0);
    nc <= 3'h0;
    cfg(32'h08);
    set_in(3'h0);
  endtask : t_runstop

  task automatic t_pair();
    cfg(32'h0C);
    cmp("pair idle", 32'h0, {31'h0, run});
    set_in(3'h1);
    cmp("pair start", 32'h1, {31'h0, run});
    set_in(3'h3);
    cmp("pair stop", 32'h0, {31'h0, run});
    set_in(3'h2);
    set_in(3'h3);
    cmp("pair both", 32'h0, {31'h0, run});
    set_in(3'h0);
    set_in(3'h1);
    set_in(3'h0);
    cmp("pair held", 32'h1, {31'h0, run});
    set_in(3'h2);
    cmp("pair stop2", 32'h0, {31'h0, run});
    set_in(3'h0);
  endtask : t_pair

  task automatic t_mode();
    int n;
    n = 0;
    want <= 3'h4;
    repeat (9) begin
      @(posedge clk);
      if (mreq === 1'b1) n++;
    end
    cmp("mode pulses", 32'h1, n);
    set_in(3'h0);
  endtask : t_mode

  task automatic t_switch();
    bus(1'b1, ADDR_ACT, 32'h6);
    bus(1'b1, ADDR_OFF0 + ADDR_STRIDE, 32'h3);
    set_in(3'h2);
    cfg(32'h48);
    set_in(3'h0);
    repeat (TK) @(posedge clk);
    cmp("alarm2 early", 32'h0, {31'h0, alm2});
    repeat (3 * TK) @(posedge clk);
    cmp("alarm2", 32'h1, {31'h0, alm2});
    cmp("continue", 32'h1, {31'h0, cont});
    cmp("stop flag", 32'h0, {31'h0, stp});
    cmp("alarm1 off", 32'h0, {31'h0, alm1});
    bus(1'b1, ADDR_ACT, 32'hA);
    cfg(32'h04);
    repeat (2 * TK) @(posedge clk);
    cmp("alarm1", 32'h1, {31'h0, alm1});
    cmp("alarm2 off", 32'h0, {31'h0, alm2});
    cmp("stop flag1", 32'h1, {31'h0, stp});
  endtask : t_switch

  task automatic t_delay();
    bus(1'b1, ADDR_DELAY0 + ADDR_STRIDE, 32'h2);
    bus(1'b1, ADDR_OFF0 + ADDR_STRIDE, 32'h0);
    cfg(32'h48);
    set_in(3'h1);
    cmp("run delayed", 32'h1, {31'h0, run});
    repeat (TK / 2) @(posedge clk);
    cmp("alarm2 delay", 32'h0, {31'h0, alm2});
    repeat (3 * TK) @(posedge clk);
    cmp("alarm2 armed", 32'h1, {31'h0, alm2});
    cmp("run stopped", 32'h0, {31'h0, run});
    set_in(3'h0);
    bus(1'b1, ADDR_CLEAR, 32'h3);
    repeat (4 * TK) @(posedge clk);
    cmp("alarm2 quiet", 32'h0, {31'h0, alm2});
    cmp("run idle", 32'h0, {31'h0, run});
  endtask : t_delay

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_defaults();
    t_runstop();
    t_pair();
    t_mode();
    t_switch();
    t_delay();
    finish_test();
  end
endmodule : tb

`default_nettype wire
